//--- core/mfs_pkg.sv
// Shared constants, types and register layout of the motor fault supervisor
package mfs_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned WAKE_DELAY_US = 1000;
  localparam int unsigned SLEEP_ENTRY_DELAY_US = 100;
  localparam int unsigned RETRY_DELAY_US = 1600;
  localparam int unsigned DIAG_STEP_US = 50;
  localparam int unsigned PUP_PULSE_US = 10;
  // Least times round up, the power-up pulse is a longest time and rounds down
  localparam int unsigned WAKE_CYCLES = (WAKE_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SLEEP_CYCLES =
    (SLEEP_ENTRY_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RETRY_CYCLES = (RETRY_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DIAG_CYCLES = (DIAG_STEP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PUP_CYCLES = (PUP_PULSE_US * 1000) / CLK_PERIOD_NS;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_BRIDGE_OFF_BIT = 2;
  localparam int CTRL_SERIAL_BIT = 3;
  localparam int CTRL_KIND1_LSB = 4;
  localparam int CTRL_KIND2_LSB = 6;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    MODE_4PIN = 2'h0,
    MODE_2PIN = 2'h1,
    MODE_PARALLEL = 2'h2,
    MODE_INDEP = 2'h3
  } mfs_mode_type;

  typedef enum logic [1:0] {
    LOAD_FULL = 2'h0,
    LOAD_TO_SUPPLY = 2'h1,
    LOAD_TO_GROUND = 2'h2,
    LOAD_NONE = 2'h3
  } mfs_load_type;

  typedef enum logic [2:0] {
    ST_SLEEP = 3'h0,
    ST_WAKE = 3'h1,
    ST_RUN = 3'h2,
    ST_SLEEP_WAIT = 3'h3,
    ST_LOCKOUT = 3'h4
  } mfs_state_type;

  typedef struct packed {
    logic sleepInN;
    logic supplyLowLockout;
    logic thermalTrip;
    logic [3:0] overcurrentTrip;
    logic [3:0] highSideSense;
    logic [3:0] lowSideSense;
  } mfs_pins_type;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [31:0] datOut;
    logic ack;
  } mfs_bus_type;

endpackage

//--- core/mfs_supervisor.sv
// Sleep, wake, open-load diagnostic and fault supervisor with Wishbone registers
`timescale 1ns/1ps
`default_nettype none

module mfs_supervisor #(
  parameter int unsigned WAKE_CYCLES = mfs_pkg::WAKE_CYCLES,
  parameter int unsigned SLEEP_CYCLES = mfs_pkg::SLEEP_CYCLES,
  parameter int unsigned RETRY_CYCLES = mfs_pkg::RETRY_CYCLES,
  parameter int unsigned DIAG_CYCLES = mfs_pkg::DIAG_CYCLES,
  parameter int unsigned PUP_CYCLES = mfs_pkg::PUP_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins and analog comparators
  input wire logic sleep_in_n,
  input wire logic supply_low_lockout,
  input wire logic thermal_trip,
  input wire logic [3:0] overcurrent_trip,
  input wire logic [3:0] high_side_sense,
  input wire logic [3:0] low_side_sense,
  // Bridge and status outputs
  output logic fault_out_n,
  output logic [3:0] halfBridgeEnable,
  output logic circuitsEnable,
  output logic readyForInputs,
  output logic [1:0] diagPhase
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  mfs_pkg::mfs_pins_type pinsMeta_q;
  mfs_pkg::mfs_pins_type pins_q;
  mfs_pkg::mfs_pins_type pinsRaw;

  assign pinsRaw = '{sleepInN: sleep_in_n, supplyLowLockout: supply_low_lockout,
    thermalTrip: thermal_trip, overcurrentTrip: overcurrent_trip,
    highSideSense: high_side_sense, lowSideSense: low_side_sense};

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinsMeta_q <= '0;
      pins_q <= '0;
    end else begin
      pinsMeta_q <= pinsRaw;
      pins_q <= pinsMeta_q;
    end
  end

  // ****************************************
  // Register bus
  // ****************************************
  mfs_pkg::mfs_bus_type bus_q;
  mfs_pkg::mfs_bus_type bus_d;
  logic [31:0] statusWord;

  always_comb begin
    bus_d = bus_q;
    bus_d.ack = wb_cyc_i & wb_stb_i & ~bus_q.ack;
    bus_d.datOut = 32'h00000000;
    if (wb_cyc_i & wb_stb_i & ~bus_q.ack) begin
      if (wb_adr_i == mfs_pkg::CTRL_ADDR) begin
        bus_d.datOut = {24'h000000, bus_q.ctrl};
      end else if (wb_adr_i == mfs_pkg::STATUS_ADDR) begin
        bus_d.datOut = statusWord;
      end
    end
    // Write lands on the edge where the master sees ack, so an aborted cycle changes nothing
    if (wb_cyc_i & wb_stb_i & bus_q.ack & wb_we_i & wb_sel_i[0] &
        (wb_adr_i == mfs_pkg::CTRL_ADDR)) begin
      bus_d.ctrl = wb_dat_i[7:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_q <= '{ctrl: mfs_pkg::CTRL_RESET, datOut: 32'h00000000, ack: 1'b0};
    end else begin
      bus_q <= bus_d;
    end
  end

  assign wb_dat_o = bus_q.datOut;
  assign wb_ack_o = bus_q.ack;

  mfs_pkg::mfs_mode_type mode;
  mfs_pkg::mfs_load_type kindPair1;
  mfs_pkg::mfs_load_type kindPair2;
  logic bridgeOffOnOpen;
  logic serialVariant;

  assign mode = mfs_pkg::mfs_mode_type'(bus_q.ctrl[mfs_pkg::CTRL_MODE_LSB +: 2]);
  assign kindPair1 = mfs_pkg::mfs_load_type'(bus_q.ctrl[mfs_pkg::CTRL_KIND1_LSB +: 2]);
  assign kindPair2 = mfs_pkg::mfs_load_type'(bus_q.ctrl[mfs_pkg::CTRL_KIND2_LSB +: 2]);
  assign bridgeOffOnOpen = bus_q.ctrl[mfs_pkg::CTRL_BRIDGE_OFF_BIT];
  assign serialVariant = bus_q.ctrl[mfs_pkg::CTRL_SERIAL_BIT];

  // ****************************************
  // Supervisor
  // ****************************************
  // Widens per-half-bridge fault bits to the set of half-bridges the mode switches together
  function automatic logic [3:0] spreadByMode(input logic [3:0] hit,
                                              input mfs_pkg::mfs_mode_type m);
    logic [3:0] res;
    res = hit;
    unique case (m)
      mfs_pkg::MODE_4PIN, mfs_pkg::MODE_2PIN: res = {{2{|hit[3:2]}}, {2{|hit[1:0]}}};
      mfs_pkg::MODE_PARALLEL: res = {4{|hit}};
      mfs_pkg::MODE_INDEP: res = hit;
    endcase
    return res;
  endfunction

  // Combines the three detection results of one output pair by its load kind
  function automatic logic [1:0] pairOpen(input mfs_pkg::mfs_load_type k, input logic full,
                                          input logic [1:0] toSupply, input logic [1:0] toGround);
    logic [1:0] res;
    res = 2'h0;
    unique case (k)
      mfs_pkg::LOAD_FULL: res = {2{full}};
      mfs_pkg::LOAD_TO_SUPPLY: res = toSupply;
      mfs_pkg::LOAD_TO_GROUND: res = toGround;
      mfs_pkg::LOAD_NONE: res = 2'h0;
    endcase
    return res;
  endfunction

  mfs_pkg::mfs_state_type state_q, state_d;
  logic [31:0] cnt_q, cnt_d;
  logic [31:0] retryCnt_q, retryCnt_d;
  logic [31:0] pupCnt_q, pupCnt_d;
  logic [1:0] fullOpen_q, fullOpen_d;
  logic [3:0] supplyOpen_q, supplyOpen_d;
  logic [3:0] openFlag_q, openFlag_d;
  logic [3:0] ocFlag_q, ocFlag_d;
  logic faultOutN_q, faultOutN_d;
  logic [3:0] bridgeEn_q, bridgeEn_d;
  logic circuitsEn_q, circuitsEn_d;
  logic ready_q, ready_d;
  logic [1:0] diagPhase_q, diagPhase_d;
  logic [3:0] groundOpen;
  logic [3:0] offMask;
  logic faultAny;
  logic pupPulse;

  assign statusWord = {17'h0, state_q, ready_q, ~faultOutN_q, pins_q.thermalTrip,
    pins_q.supplyLowLockout, ocFlag_q, openFlag_q};

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    retryCnt_d = retryCnt_q;
    fullOpen_d = fullOpen_q;
    supplyOpen_d = supplyOpen_q;
    openFlag_d = openFlag_q;
    ocFlag_d = ocFlag_q;
    ready_d = ready_q;
    diagPhase_d = 2'h0;
    groundOpen = pins_q.highSideSense;
    pupPulse = pupCnt_q < PUP_CYCLES;
    pupCnt_d = pupPulse ? pupCnt_q + 32'h1 : pupCnt_q;
    unique case (state_q)
      mfs_pkg::ST_SLEEP: begin
        // Sleep acts as a reset of latched diagnostics
        openFlag_d = 4'h0;
        ocFlag_d = 4'h0;
        retryCnt_d = 32'h0;
        ready_d = 1'b0;
        cnt_d = 32'h0;
        if (pins_q.sleepInN) begin
          state_d = mfs_pkg::ST_WAKE;
        end
      end
      mfs_pkg::ST_WAKE: begin
        cnt_d = cnt_q + 32'h1;
        if (cnt_q < DIAG_CYCLES) begin
          diagPhase_d = 2'h1;
        end else if (cnt_q < 2 * DIAG_CYCLES) begin
          diagPhase_d = 2'h2;
        end else if (cnt_q < 3 * DIAG_CYCLES) begin
          diagPhase_d = 2'h3;
        end
        if (cnt_q == DIAG_CYCLES - 1) begin
          fullOpen_d[0] = pins_q.highSideSense[0] & pins_q.lowSideSense[1];
          fullOpen_d[1] = pins_q.highSideSense[2] & pins_q.lowSideSense[3];
        end
        if (cnt_q == 2 * DIAG_CYCLES - 1) begin
          supplyOpen_d = pins_q.lowSideSense;
        end
        if (cnt_q == 3 * DIAG_CYCLES - 1) begin
          // Set only: a flag already latched stays until sleep or lockout
          openFlag_d = openFlag_q |
            {pairOpen(kindPair2, fullOpen_q[1], supplyOpen_q[3:2], groundOpen[3:2]),
             pairOpen(kindPair1, fullOpen_q[0], supplyOpen_q[1:0], groundOpen[1:0])};
        end
        if (cnt_q >= WAKE_CYCLES - 1) begin
          state_d = mfs_pkg::ST_RUN;
          ready_d = 1'b1;
        end
        if (!pins_q.sleepInN) begin
          state_d = mfs_pkg::ST_SLEEP_WAIT;
          cnt_d = 32'h0;
        end
      end
      mfs_pkg::ST_RUN, mfs_pkg::ST_SLEEP_WAIT: begin
        // Overcurrent retry: a trip present at expiry re-latches at once
        if (ocFlag_q != 4'h0) begin
          retryCnt_d = retryCnt_q + 32'h1;
        end
        ocFlag_d = ocFlag_q | pins_q.overcurrentTrip;
        if (retryCnt_q >= RETRY_CYCLES - 1) begin
          ocFlag_d = pins_q.overcurrentTrip;
          retryCnt_d = 32'h0;
        end
        if (state_q == mfs_pkg::ST_RUN) begin
          if (!pins_q.sleepInN) begin
            state_d = mfs_pkg::ST_SLEEP_WAIT;
            cnt_d = 32'h0;
          end
        end else begin
          cnt_d = cnt_q + 32'h1;
          if (pins_q.sleepInN) begin
            state_d = ready_q ? mfs_pkg::ST_RUN : mfs_pkg::ST_WAKE;
            cnt_d = 32'h0;
          end else if (cnt_q >= SLEEP_CYCLES - 1) begin
            state_d = mfs_pkg::ST_SLEEP;
          end
        end
      end
      mfs_pkg::ST_LOCKOUT: begin
        // Internal logic is reset; recovery restarts the wake sequence, or returns to sleep while sleep_in_n is low
        openFlag_d = 4'h0;
        ocFlag_d = 4'h0;
        retryCnt_d = 32'h0;
        ready_d = 1'b0;
        cnt_d = 32'h0;
        if (!pins_q.supplyLowLockout) begin
          state_d = pins_q.sleepInN ? mfs_pkg::ST_WAKE : mfs_pkg::ST_SLEEP;
        end
      end
      default: begin
        state_d = mfs_pkg::ST_SLEEP;
      end
    endcase
    if (pins_q.supplyLowLockout) begin
      state_d = mfs_pkg::ST_LOCKOUT;
    end

    // Hi-Z masks; open load without the serial variant never turns a bridge off
    offMask = spreadByMode(ocFlag_q, mode);
    if (serialVariant & bridgeOffOnOpen) begin
      offMask = offMask | spreadByMode(openFlag_q, mode);
    end
    if (pins_q.thermalTrip) begin
      offMask = 4'hF;
    end
    faultAny = (|openFlag_q) | (|ocFlag_q) | pins_q.thermalTrip |
      pins_q.supplyLowLockout;
    circuitsEn_d = 1'b1;
    bridgeEn_d = 4'h0;
    unique case (state_q)
      mfs_pkg::ST_SLEEP: begin
        circuitsEn_d = 1'b0;
        faultAny = pins_q.supplyLowLockout;
      end
      mfs_pkg::ST_LOCKOUT: begin
        circuitsEn_d = 1'b0;
      end
      mfs_pkg::ST_WAKE: begin
        bridgeEn_d = 4'h0;
      end
      mfs_pkg::ST_RUN, mfs_pkg::ST_SLEEP_WAIT: begin
        bridgeEn_d = ~offMask;
      end
      default: begin
        circuitsEn_d = 1'b0;
      end
    endcase
    if (pins_q.supplyLowLockout) begin
      bridgeEn_d = 4'h0;
      circuitsEn_d = 1'b0;
    end
    faultOutN_d = ~(faultAny | pupPulse);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= mfs_pkg::ST_SLEEP;
      cnt_q <= 32'h0;
      retryCnt_q <= 32'h0;
      pupCnt_q <= 32'h0;
      fullOpen_q <= 2'h0;
      supplyOpen_q <= 4'h0;
      openFlag_q <= 4'h0;
      ocFlag_q <= 4'h0;
      faultOutN_q <= 1'b1;
      bridgeEn_q <= 4'h0;
      circuitsEn_q <= 1'b0;
      ready_q <= 1'b0;
      diagPhase_q <= 2'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      retryCnt_q <= retryCnt_d;
      pupCnt_q <= pupCnt_d;
      fullOpen_q <= fullOpen_d;
      supplyOpen_q <= supplyOpen_d;
      openFlag_q <= openFlag_d;
      ocFlag_q <= ocFlag_d;
      faultOutN_q <= faultOutN_d;
      bridgeEn_q <= bridgeEn_d;
      circuitsEn_q <= circuitsEn_d;
      ready_q <= ready_d;
      diagPhase_q <= diagPhase_d;
    end
  end

  assign fault_out_n = faultOutN_q;
  assign halfBridgeEnable = bridgeEn_q;
  assign circuitsEnable = circuitsEn_q;
  assign readyForInputs = ready_q;
  assign diagPhase = diagPhase_q;

endmodule // mfs_supervisor

`default_nettype wire

//--- tb/mfs_pin_model.sv
// Controller-side pin model launching pin levels on the clock
`timescale 1ns/1ps
`default_nettype none
module mfs_pin_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Requested and driven pin levels
  input wire mfs_pkg::mfs_pins_type cmd,
  output var mfs_pkg::mfs_pins_type pins
);
  // Sleep stays low through reset so the first wake is under bench control
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pins <= '0;
    end else begin
      pins <= cmd;
    end
  end
endmodule // mfs_pin_model
`default_nettype wire

//--- tb/mfs_supervisor_monitor.sv
// Concurrent checks on the supervisor ports
`timescale 1ns/1ps
`default_nettype none
module mfs_supervisor_monitor #(
  parameter int unsigned DIAG_CYCLES = 8,
  parameter int unsigned PUP_CYCLES = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Pins
  input wire logic sleep_in_n,
  input wire logic supply_low_lockout,
  input wire logic thermal_trip,
  input wire logic [3:0] overcurrent_trip,
  // Outputs
  input wire logic fault_out_n,
  input wire logic [3:0] halfBridgeEnable,
  input wire logic circuitsEnable,
  input wire logic readyForInputs,
  input wire logic [1:0] diagPhase
);
  // ****************************************
  // Properties
  // ****************************************
  // Repeat counts are written for the bench values 8 and 4
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  property p_diag_steps;
    $rose(diagPhase == 2'h1) |-> (diagPhase == 2'h1)[*8] ##1 (diagPhase == 2'h2)[*8]
      ##1 (diagPhase == 2'h3)[*8];
  endproperty
  a_diag_steps: assert property (p_diag_steps) else $error("diag steps");
  property p_diag_hiz;
    diagPhase != 2'h0 |-> halfBridgeEnable == 4'h0 && !readyForInputs;
  endproperty
  a_diag_hiz: assert property (p_diag_hiz) else $error("diag not in wake");
  property p_sleep_hiz;
    !circuitsEnable |-> halfBridgeEnable == 4'h0;
  endproperty
  a_sleep_hiz: assert property (p_sleep_hiz) else $error("bridges on while off");
  property p_pup;
    $past(rst) |=> (!fault_out_n)[*4];
  endproperty
  a_pup: assert property (p_pup) else $error("power-up pulse");
  // Cycles since reset, saturating, so the pulse is also shown to end
  logic [7:0] sinceRst_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sinceRst_q <= 8'h00;
    end else if (sinceRst_q != 8'hFF) begin
      sinceRst_q <= sinceRst_q + 8'h01;
    end
  end
  property p_pup_end;
    sinceRst_q == 8'(PUP_CYCLES + 1) |-> fault_out_n;
  endproperty
  a_pup_end: assert property (p_pup_end) else $error("power-up pulse too long");
  property p_sleep_wait;
    $fell(sleep_in_n) && readyForInputs |-> circuitsEnable[*8] ##[4:9] !circuitsEnable;
  endproperty
  a_sleep_wait: assert property (p_sleep_wait) else $error("sleep entry delay");
  property p_uv;
    supply_low_lockout[*6] |-> !circuitsEnable && halfBridgeEnable == 4'h0 && !fault_out_n;
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage");
  property p_oc;
    $rose(overcurrent_trip[0]) && readyForInputs |-> ##[1:6] !fault_out_n;
  endproperty
  a_oc: assert property (p_oc) else $error("overcurrent fault");
  property p_thermal;
    thermal_trip[*6] ##0 readyForInputs |-> halfBridgeEnable == 4'h0 && !fault_out_n;
  endproperty
  a_thermal: assert property (p_thermal) else $error("thermal");
  c_diag: cover property (diagPhase == 2'h3);
  c_oc: cover property ($rose(overcurrent_trip[0]) && readyForInputs);
  c_thermal: cover property (thermal_trip && readyForInputs);
endmodule // mfs_supervisor_monitor
bind mfs_supervisor mfs_supervisor_monitor #(.DIAG_CYCLES(DIAG_CYCLES), .PUP_CYCLES(PUP_CYCLES))
  i_mon (.sys_clk(sys_clk), .rst(rst), .sleep_in_n(sleep_in_n),
  .supply_low_lockout(supply_low_lockout), .thermal_trip(thermal_trip),
  .overcurrent_trip(overcurrent_trip), .fault_out_n(fault_out_n),
  .halfBridgeEnable(halfBridgeEnable), .circuitsEnable(circuitsEnable),
  .readyForInputs(readyForInputs), .diagPhase(diagPhase));
`default_nettype wire

//--- tb/mfs_supervisor_tb.sv
// Self-checking bench for the motor fault supervisor
`timescale 1ns/1ps
`default_nettype none
module mfs_supervisor_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack, faultN, ce, rdy;
  logic [3:0] hbe;
  logic [23:0] c;
  mfs_pkg::mfs_pins_type cmd = '0;
  mfs_pkg::mfs_pins_type pins;
  int n_fail = 0;
  int samples_checked = 0;
  int n;
  // Case word: ctrl, high sense, low sense, expected flags, expected bridges
  logic [23:0] olCase [8] = '{24'h0C123C, 24'h0E1230, 24'h1F011E, 24'h2D202C,
    24'h04123F, 24'h08123F, 24'h0C48C3, 24'hCC580F};
  logic [3:0] ocExp [4] = '{4'hC, 4'hC, 4'h0, 4'hE};
  always #5 sys_clk = ~sys_clk;
  mfs_pin_model i_pins (.sys_clk(sys_clk), .rst(rst), .cmd(cmd), .pins(pins));
  mfs_supervisor #(.WAKE_CYCLES(40), .SLEEP_CYCLES(10), .RETRY_CYCLES(20), .DIAG_CYCLES(8),
    .PUP_CYCLES(4)) i_dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .sleep_in_n(pins.sleepInN), .supply_low_lockout(pins.supplyLowLockout),
    .thermal_trip(pins.thermalTrip), .overcurrent_trip(pins.overcurrentTrip),
    .high_side_sense(pins.highSideSense), .low_side_sense(pins.lowSideSense),
    .fault_out_n(faultN), .halfBridgeEnable(hbe), .circuitsEnable(ce),
    .readyForInputs(rdy), .diagPhase());
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    do @(posedge sys_clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  function automatic logic lvl(input int w);
    case (w)
      0: return faultN;
      1: return ce;
      default: return rdy;
    endcase
  endfunction
  // Bounded wait; a miss shows up in the compare that follows
  task automatic until_level(input int w, input logic v, input int k);
    repeat (k) if (lvl(w) !== v) @(posedge sys_clk);
  endtask
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    tick(5);
    rst <= 1'b0;
    wb(1'b0, mfs_pkg::CTRL_ADDR, 32'h0);
    chk(q, 32'(mfs_pkg::CTRL_RESET));
    wb(1'b1, 8'h08, 32'hFFFFFFFF);
    wb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h0);
    for (int i = 0; i < 8; i++) begin
      c = olCase[i];
      cmd.sleepInN <= 1'b0;
      until_level(1, 1'b0, 60);
      tick(3);
      chk({27'h0, faultN, hbe}, 32'h10);
      wb(1'b1, mfs_pkg::CTRL_ADDR, {24'h0, c[23:16]});
      cmd.highSideSense <= c[15:12];
      cmd.lowSideSense <= c[11:8];
      cmd.sleepInN <= 1'b1;
      until_level(2, 1'b1, 200);
      cmd.highSideSense <= 4'h0;
      cmd.lowSideSense <= 4'h0;
      tick(5);
      wb(1'b0, mfs_pkg::STATUS_ADDR, 32'h0);
      chk(q[3:0], c[7:4]);
      chk({q[10], faultN, hbe}, {|c[7:4], ~|c[7:4], c[3:0]});
    end
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, mfs_pkg::CTRL_ADDR, 32'(m) | 32'h0C);
      wb(1'b0, mfs_pkg::CTRL_ADDR, 32'h0);
      chk(q, 32'(m) | 32'h0C);
      cmd.overcurrentTrip <= 4'h1;
      tick(2);
      cmd.overcurrentTrip <= 4'h0;
      until_level(0, 1'b0, 10);
      tick(2);
      chk(hbe, ocExp[m]);
      wb(1'b0, mfs_pkg::STATUS_ADDR, 32'h0);
      chk(q[4], 1'b1);
      n = 0;
      while (faultN !== 1'b1 && n < 60) begin
        @(posedge sys_clk);
        n++;
      end
      tick(2);
      chk(n >= 10, 1'b1);
      chk({faultN, hbe}, 5'h1F);
    end
    cmd.thermalTrip <= 1'b1;
    tick(6);
    chk({faultN, hbe}, 5'h00);
    cmd.thermalTrip <= 1'b0;
    tick(6);
    chk({faultN, hbe}, 5'h1F);
    // Overlap: thermal clears while the overcurrent retry still runs
    cmd.thermalTrip <= 1'b1;
    cmd.overcurrentTrip <= 4'h1;
    tick(2);
    cmd.overcurrentTrip <= 4'h0;
    tick(4);
    cmd.thermalTrip <= 1'b0;
    tick(5);
    chk(faultN, 1'b0);
    until_level(0, 1'b1, 60);
    tick(2);
    chk({faultN, hbe}, 5'h1F);
    cmd.supplyLowLockout <= 1'b1;
    tick(6);
    chk({ce, faultN, hbe}, 32'h0);
    cmd.supplyLowLockout <= 1'b0;
    tick(10);
    until_level(2, 1'b1, 200);
    tick(2);
    chk({rdy, faultN, hbe}, 6'h3F);
    close_out();
  end
  // Whole sequence takes under 1000 cycles
  initial begin
    #500000;
    n_fail++;
    close_out();
  end
endmodule // mfs_supervisor_tb
`default_nettype wire
